//--- shared/bcr_map.vh
// How it works
// RULE1 - writing one to bit 6 drives a reset sequence onto secondary bus
// RULE2 - clearing bit 6 releases the secondary bus from reset
// RULE3 - warm reset clears reset, abort mode and display enable bits
// RULE4 - destination master abort answers host link with error plus nxa
// RULE5 - abort mode clear: writes complete normally, reads return all ones
// RULE6 - compat mode with abort mode: target abort nonposted, error pin posted
// RULE7 - generic mode with abort mode: target abort nonposted, sync flood posted; the code floods only while serr_en is set
// RULE8 - memory 0A0000h through 0BFFFFh is legacy display memory
// RULE9 - io below 64KB with low bits 3B0h-3BBh or 3C0h-3DFh is legacy display
// RULE10 - io address bits 15:10 ignored so every alias matches
// RULE11 - enable set: forward display addresses downstream, block them upstream
// RULE12 - software keeps enable clear while mapping extensions are active
`ifndef BCR_MAP_VH
`define BCR_MAP_VH
`define BCR_OFS_CTRL      12'h03C
`define BCR_OFS_STAT      12'h040
`define BCR_OFS_IEN       12'h044
`define BCR_OFS_ICLR      12'h048
`define BCR_BIT_SBR       6
`define BCR_BIT_MAM       5
`define BCR_BIT_VGA       3
`define BCR_CTRL_RST      16'h0000
`define BCR_CTRL_WMASK    16'h0068
`define BCR_MEM_LO        40'h00000A0000
`define BCR_MEM_HI        40'h00000BFFFF
`define BCR_IO_LIM        32'h00010000
`define BCR_IO_A_LO       10'h3B0
`define BCR_IO_A_HI       10'h3BB
`define BCR_IO_B_LO       10'h3C0
`define BCR_IO_B_HI       10'h3DF
`define BCR_SBR_MIN       8'h08
`define BCR_ST_SBR        0
`define BCR_ST_ABORT      1
`define BCR_ST_POSTERR    2
`define BCR_ST_W          3
`endif

//--- src/bcr_bridge_ctrl.v
`include "bcr_map.vh"
`default_nettype none
module bcr_bridge_ctrl #(
    parameter SBR_MIN_CYC = `BCR_SBR_MIN
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // system error enable from command register
    input  wire        serr_en,
    input  wire        compat_sub_mode,
    input  wire        fatal_sel,
    // abort report from the forwarding path
    input  wire        abort_valid,
    input  wire        abort_posted,
    input  wire        abort_is_read,
    // address classification request
    input  wire        cls_valid,
    input  wire        cls_is_io,
    input  wire        cls_dir_up,
    input  wire [39:0] cls_addr,
    input  wire        range_hit,
    // abort responses
    output reg         rsp_valid,
    output reg         rsp_err,
    output reg         rsp_nxa,
    output reg         rsp_all_ones,
    output reg         rsp_complete,
    output reg         fatal_error_pin_n,
    output reg         nonfatal_error_pin_n,
    output reg         sync_flood,
    // classification result
    output reg         cls_done,
    output reg         cls_legacy,
    output reg         cls_forward,
    // secondary bus reset and interrupt
    output reg         sec_bus_rst,
    output reg         irq,
    output reg  [15:0] bridge_control_q
);

////////////////////////////////////////////////////////////////////////////////
// functions

// legacy display memory window
function mem_hit;
    input [39:0] a;
    begin
        mem_hit = (a >= `BCR_MEM_LO) && (a <= `BCR_MEM_HI); // RULE8
    end
endfunction

// legacy display io, upper bits aliased
function io_hit;
    input [39:0] a;
    reg [9:0] lo;
    begin
        lo = a[9:0]; // RULE10
        io_hit = (a[39:16] == 24'h000000) && // RULE9
                 (((lo >= `BCR_IO_A_LO) && (lo <= `BCR_IO_A_HI)) ||
                  ((lo >= `BCR_IO_B_LO) && (lo <= `BCR_IO_B_HI)));
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus capture

reg        ph_reg;
reg        ph_wr_reg;
reg [11:0] ph_adr_reg;
reg [15:0] ctrl_reg;
reg [`BCR_ST_W-1:0] stat_reg;
reg [`BCR_ST_W-1:0] ien_reg;
reg [7:0]  sbr_cnt_reg;
reg        sbr_req_reg;

wire take = hsel && hready && htrans[1];
wire wr_ctrl = ph_reg && ph_wr_reg && (ph_adr_reg == `BCR_OFS_CTRL);
wire wr_ien  = ph_reg && ph_wr_reg && (ph_adr_reg == `BCR_OFS_IEN);
wire wr_iclr = ph_reg && ph_wr_reg && (ph_adr_reg == `BCR_OFS_ICLR);
wire vga_en  = ctrl_reg[`BCR_BIT_VGA];
wire mam     = ctrl_reg[`BCR_BIT_MAM];
wire sbr_rise = wr_ctrl && hwdata[`BCR_BIT_SBR] && !ctrl_reg[`BCR_BIT_SBR];
wire post_err = abort_valid && mam && abort_posted;

// address phase register
always @(posedge clock or posedge rst) begin
    if (rst) begin
        ph_reg     <= 1'b0;
        ph_wr_reg  <= 1'b0;
        ph_adr_reg <= 12'h000;
    end else if (hready) begin
        ph_reg     <= take;
        ph_wr_reg  <= hwrite;
        ph_adr_reg <= {haddr[11:2], 2'b00};
    end
end

////////////////////////////////////////////////////////////////////////////////
// control, status, enable registers

// control register, only the modelled bits are writable
always @(posedge clock or posedge rst) begin
    if (rst) begin
        ctrl_reg <= `BCR_CTRL_RST; // RULE3
    end else if (wr_ctrl) begin
        ctrl_reg <= hwdata[15:0] & `BCR_CTRL_WMASK; // RULE1 RULE2
    end
end

// interrupt enable register, same layout as status
always @(posedge clock or posedge rst) begin
    if (rst) begin
        ien_reg <= {`BCR_ST_W{1'b0}};
    end else if (wr_ien) begin
        ien_reg <= hwdata[`BCR_ST_W-1:0];
    end
end

// status events and write-one-to-clear mask
wire [`BCR_ST_W-1:0] stat_set = {post_err, abort_valid, sbr_rise};
wire [`BCR_ST_W-1:0] stat_clr = {`BCR_ST_W{wr_iclr}} & hwdata[`BCR_ST_W-1:0];

// sticky status, an event in the clear cycle wins
always @(posedge clock or posedge rst) begin
    if (rst) begin
        stat_reg <= {`BCR_ST_W{1'b0}};
    end else begin
        stat_reg <= (stat_reg & ~stat_clr) | stat_set;
    end
end

////////////////////////////////////////////////////////////////////////////////
// secondary bus reset sequence, held at least the minimum

always @(posedge clock or posedge rst) begin
    if (rst) begin
        sbr_cnt_reg <= 8'h00;
        sec_bus_rst <= 1'b0;
    end else begin
        if (sbr_rise)
            sbr_cnt_reg <= SBR_MIN_CYC[7:0]; // RULE1
        else if (sbr_cnt_reg != 8'h00)
            sbr_cnt_reg <= sbr_cnt_reg - 8'h01;
        sec_bus_rst <= ctrl_reg[`BCR_BIT_SBR] || (sbr_cnt_reg != 8'h00); // RULE1 RULE2
    end
end

////////////////////////////////////////////////////////////////////////////////
// bus answer and interrupt

reg [31:0] rdata_next;

// read data selection by word offset
always @* begin
    rdata_next = 32'h00000000;
    case ({haddr[11:2], 2'b00})
        `BCR_OFS_CTRL: rdata_next = {16'h0000, ctrl_reg};
        `BCR_OFS_STAT: rdata_next = {{(32-`BCR_ST_W){1'b0}}, stat_reg};
        `BCR_OFS_IEN:  rdata_next = {{(32-`BCR_ST_W){1'b0}}, ien_reg};
        default:       rdata_next = 32'h00000000;
    endcase
end

// zero wait answer, read data stands in the data phase
always @(posedge clock or posedge rst) begin
    if (rst) begin
        hrdata           <= 32'h00000000;
        hreadyout        <= 1'b1;
        hresp            <= 1'b0;
        irq              <= 1'b0;
        bridge_control_q <= 16'h0000;
    end else begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        irq       <= |(stat_reg & ien_reg);
        bridge_control_q <= ctrl_reg;
        if (take && !hwrite) begin
            hrdata <= rdata_next;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// master abort handling

reg  rsp_err_next;
reg  rsp_nxa_next;
reg  rsp_all_ones_next;
reg  rsp_complete_next;
reg  fatal_pin_n_next;
reg  nonfatal_pin_n_next;
wire flood_set = post_err && !compat_sub_mode && serr_en;

// answer decode for one abort report
always @* begin
    rsp_err_next        = 1'b0;
    rsp_nxa_next        = 1'b0;
    rsp_all_ones_next   = 1'b0;
    rsp_complete_next   = 1'b0;
    fatal_pin_n_next    = 1'b1;
    nonfatal_pin_n_next = 1'b1;
    if (abort_valid) begin
        if (!mam) begin
            rsp_err_next      = !abort_posted;           // RULE4
            rsp_nxa_next      = !abort_posted;           // RULE4
            rsp_all_ones_next = abort_is_read;           // RULE5
            rsp_complete_next = !abort_is_read;          // RULE5
        end else if (!abort_posted) begin
            rsp_err_next = 1'b1;                         // RULE6 RULE7
        end else if (compat_sub_mode) begin
            fatal_pin_n_next    = !fatal_sel;            // RULE6
            nonfatal_pin_n_next = fatal_sel;             // RULE6
        end
    end
end

// answer registers, one cycle after the report
always @(posedge clock or posedge rst) begin
    if (rst) begin
        rsp_valid            <= 1'b0;
        rsp_err              <= 1'b0;
        rsp_nxa              <= 1'b0;
        rsp_all_ones         <= 1'b0;
        rsp_complete         <= 1'b0;
        fatal_error_pin_n    <= 1'b1;
        nonfatal_error_pin_n <= 1'b1;
        sync_flood           <= 1'b0;
    end else begin
        rsp_valid            <= abort_valid;
        rsp_err              <= rsp_err_next;
        rsp_nxa              <= rsp_nxa_next;
        rsp_all_ones         <= rsp_all_ones_next;
        rsp_complete         <= rsp_complete_next;
        fatal_error_pin_n    <= fatal_pin_n_next;
        nonfatal_error_pin_n <= nonfatal_pin_n_next;
        // flood stays until reset
        if (flood_set)
            sync_flood <= 1'b1;                             // RULE7
    end
end

////////////////////////////////////////////////////////////////////////////////
// legacy display classification

// address falls in a legacy display window of its space
wire cls_hit = cls_is_io ? io_hit(cls_addr) : mem_hit(cls_addr);

// result registers, one cycle after the request
always @(posedge clock or posedge rst) begin
    if (rst) begin
        cls_done    <= 1'b0;
        cls_legacy  <= 1'b0;
        cls_forward <= 1'b0;
    end else begin
        cls_done   <= cls_valid;
        cls_legacy <= cls_hit;
        if (cls_hit && vga_en)
            cls_forward <= !cls_dir_up;                     // RULE11
        else
            cls_forward <= cls_dir_up ? !range_hit : range_hit;
    end
end

endmodule
`default_nettype wire

//--- testbench/bcr_bridge_ctrl_monitor.sv
`default_nettype none
module bcr_ctrl_mon #(parameter SBR_MIN_CYC = 8) (
    // clock, reset, requests
    input wire logic        clock, rst, abort_valid, abort_posted, abort_is_read,
    input wire logic        compat_sub_mode, cls_valid,
    // answers and state
    input wire logic        rsp_valid, rsp_err, rsp_nxa, rsp_all_ones, cls_done,
    input wire logic        fatal_error_pin_n, nonfatal_error_pin_n, sec_bus_rst,
    input wire logic [15:0] bridge_control_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // short names for the abort qualifiers
    wire logic mam = bridge_control_q[5];
    wire logic np = abort_valid && !abort_posted;
    wire logic pe = abort_valid && abort_posted && mam;
    // secondary reset steps
    sequence s_set; $rose(bridge_control_q[6]); endsequence
    sequence s_hold; sec_bus_rst [*2]; endsequence
    property p_rsp; abort_valid |=> rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("abort unanswered");
    property p_nxa; np && !mam |=> rsp_err && rsp_nxa; endproperty
    a_nxa: assert property (p_nxa) else $error("abort lacks nxa");
    property p_ones; abort_valid && abort_is_read && !mam |=> rsp_all_ones; endproperty
    a_ones: assert property (p_ones) else $error("read abort not all ones");
    property p_ta; np && mam |=> rsp_err && !rsp_nxa; endproperty
    a_ta: assert property (p_ta) else $error("no target abort");
    property p_pin; pe && compat_sub_mode |=> !(fatal_error_pin_n && nonfatal_error_pin_n);
    endproperty
    a_pin: assert property (p_pin) else $error("no error pin");
    property p_cls; cls_valid |=> cls_done; endproperty
    a_cls: assert property (p_cls) else $error("classify unanswered");
    property p_sr; s_set |=> s_hold; endproperty
    a_sr: assert property (p_sr) else $error("secondary reset missing");
    property p_rel; !bridge_control_q[6] [*8] |=> !sec_bus_rst; endproperty
    a_rel: assert property (p_rel) else $error("secondary reset stuck");
endmodule
bind bcr_bridge_ctrl bcr_ctrl_mon #(.SBR_MIN_CYC(SBR_MIN_CYC)) bcr_ctrl_mon_inst (.*);
`default_nettype wire

//--- testbench/bcr_fwd_agent.sv
`default_nettype none
module bcr_fwd_agent (
    // clock
    input wire logic  clock,
    // abort report and classify request
    output logic      abort_valid, abort_posted, abort_is_read, cls_valid,
    output logic      cls_is_io, cls_dir_up, range_hit,
    output logic [39:0] cls_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle at time zero
    initial begin
        abort_valid = 1'b0;
        cls_valid = 1'b0;
    end
    // one-cycle abort report, qualifiers scrambled after
    task automatic abort(input logic p, input logic r);
        @(posedge clock);
        abort_valid <= 1'b1;
        abort_posted <= p;
        abort_is_read <= r;
        @(posedge clock);
        abort_valid <= 1'b0;
        abort_posted <= ~p;
        abort_is_read <= ~r;
    endtask
    // one-cycle classify request, address scrambled after
    task automatic cls(input logic io, input logic up, input logic hit, input logic [39:0] a);
        @(posedge clock);
        cls_valid <= 1'b1;
        cls_is_io <= io;
        cls_dir_up <= up;
        range_hit <= hit;
        cls_addr <= a;
        @(posedge clock);
        cls_valid <= 1'b0;
        cls_addr <= ~a;
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_bridge_control_reset_abort_vga.sv
`include "bcr_map.vh"
`default_nettype none
module tb_bridge_control_reset_abort_vga;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, fatal_sel = 1'b0;
    logic        serr_en = 1'b0, compat_sub_mode = 1'b1, hreadyout, hresp, irq;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata;
    logic        abort_valid, abort_posted, abort_is_read, cls_valid, cls_is_io, cls_dir_up;
    logic        range_hit, rsp_valid, rsp_err, rsp_nxa, rsp_all_ones, rsp_complete;
    logic        fatal_error_pin_n, nonfatal_error_pin_n, sync_flood, cls_done;
    logic        cls_legacy, cls_forward, sec_bus_rst;
    logic [15:0] bridge_control_q;
    logic [39:0] cls_addr;
    logic [39:0] adr [9] = '{40'hA0000, 40'hBFFFF, 40'h9FFFF, 40'hC0000, 40'h3BB,
                             40'h3BC, 40'hFFDF, 40'h103C0, 40'hA0000};
    // enable, io, up, hit, legacy, forward
    logic [5:0]  flg [9] = '{6'h23, 6'h2E, 6'h20, 6'h20, 6'h33, 6'h30, 6'h33, 6'h30, 6'h02};
    int          mismatches = 0, n_tests = 0, i;
    wire logic [4:0] rsp = {rsp_valid, rsp_err, rsp_nxa, rsp_all_ones, rsp_complete};
    bcr_bridge_ctrl #(.SBR_MIN_CYC(2)) bcr_bridge_ctrl_inst (.*, .hready(hreadyout),
                                                             .hsize(3'h2));
    bcr_fwd_agent bcr_fwd_agent_inst (.*);
    // clock
    always #25 clock = ~clock;
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // wait for hready at an edge, bounded
    task automatic rdy;
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            chk(hreadyout, 32'h1);
            test_done;
        end
    endtask
    // one single ahb transfer
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
    endtask
    // read and compare
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(q, e);
        chk({hreadyout, hresp}, 32'h2);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rd(`BCR_OFS_CTRL, 32'h0);
        chk({sec_bus_rst, fatal_error_pin_n, nonfatal_error_pin_n}, 32'h3);
        ahb(1'b1, `BCR_OFS_CTRL, 32'hFFFF);
        rd(`BCR_OFS_CTRL, `BCR_CTRL_WMASK);
        chk(sec_bus_rst, 32'h1);
        chk(bridge_control_q, `BCR_CTRL_WMASK);
        ahb(1'b1, `BCR_OFS_CTRL, 32'h0);
        repeat (4) @(posedge clock);
        chk(sec_bus_rst, 32'h0);
        $display("reset test done");
        fatal_sel <= 1'b1;
        serr_en <= 1'b1;
        bcr_fwd_agent_inst.abort(1'b0, 1'b1);
        #1 chk(rsp, 32'h1E);
        bcr_fwd_agent_inst.abort(1'b0, 1'b0);
        #1 chk(rsp, 32'h1D);
        ahb(1'b1, `BCR_OFS_CTRL, 32'h20);
        bcr_fwd_agent_inst.abort(1'b0, 1'b1);
        #1 chk(rsp, 32'h18);
        bcr_fwd_agent_inst.abort(1'b1, 1'b0);
        #1 chk({fatal_error_pin_n, nonfatal_error_pin_n}, 32'h1);
        compat_sub_mode <= 1'b0;
        bcr_fwd_agent_inst.abort(1'b1, 1'b0);
        #1 chk(sync_flood, 32'h1);
        $display("abort test done");
        rd(`BCR_OFS_STAT, 32'h7);
        chk(irq, 32'h0);
        ahb(1'b1, `BCR_OFS_IEN, 32'h2);
        repeat (2) @(posedge clock);
        chk(irq, 32'h1);
        ahb(1'b1, `BCR_OFS_ICLR, 32'h7);
        rd(`BCR_OFS_STAT, 32'h0);
        chk(irq, 32'h0);
        rd(12'h100, 32'h0);
        $display("interrupt test done");
        // mapping extensions are never active here
        for (i = 0; i < 9; i++) begin
            ahb(1'b1, `BCR_OFS_CTRL, {28'h0, flg[i][5], 3'h0});
            bcr_fwd_agent_inst.cls(flg[i][4], flg[i][3], flg[i][2], adr[i]);
            #1 chk({cls_done, cls_legacy, cls_forward}, {29'h1, flg[i][1:0]});
        end
        $display("classify test done");
        ahb(1'b1, `BCR_OFS_CTRL, 32'h68);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(`BCR_OFS_CTRL, 32'h0);
        chk({sec_bus_rst, sync_flood}, 32'h0);
        $display("warm reset test done");
        test_done;
    end
endmodule
`default_nettype wire
